// File: verilog/rmc_pkg.sv
package rmc_pkg;
    localparam int RMC_NREG = 36;
    localparam int RMC_AW   = 10;
    localparam logic [RMC_AW-1:0] RMC_ADDR [RMC_NREG] = '{
        10'h102, 10'h10c, 10'h10d, 10'h10e, 10'h10f, 10'h13e,
        10'h304, 10'h305, 10'h306, 10'h30e, 10'h30f, 10'h32c,
        10'h335, 10'h389, 10'h38b, 10'h39b, 10'h3b2, 10'h3b4,
        10'h3b6, 10'h3b7, 10'h3b8, 10'h3ba, 10'h3bc, 10'h3bf,
        10'h3c4, 10'h3d2, 10'h3d3, 10'h3d4, 10'h3d5, 10'h3d6,
        10'h3d7, 10'h3e0, 10'h3f3, 10'h3f7, 10'h3f8, 10'h3f9
    };
    localparam int RMC_I_SYNC0 = 1;
    localparam int RMC_I_SYNC1 = 2;
    localparam int RMC_I_SYNC2 = 3;
    localparam int RMC_I_SCFG  = 4;
    localparam int RMC_I_MODE  = 5;
    localparam int RMC_I_RXFE  = 15;
    localparam int RMC_I_PCHK  = 32;
    localparam int RMC_I_AFCC  = 33;
    localparam int RMC_I_AFCR  = 35;
    localparam logic [RMC_AW-1:0] RMC_STATUS_ADDR = 10'h3fa;
    localparam logic [7:0] RMC_ZERO_RST = 8'h00;
    localparam logic [7:0] RMC_RXFE_RST = 8'h10;
    localparam logic [7:0] RMC_PCHK_RST = 8'h05;
    localparam logic [7:0] RMC_MODE_PKT   = 8'h04;
    localparam logic [7:0] RMC_MODE_SPORT = 8'h03;
    localparam logic [7:0] RMC_AFC_ON     = 8'h07;
    localparam int RMC_LEN_LSB = 0;
    localparam int RMC_LEN_W   = 5;
    localparam int RMC_TOL_LSB = 5;
    localparam int RMC_TOL_W   = 2;
    localparam int RMC_LNA_LSB = 4;
    localparam int RMC_LNA_W   = 3;
    localparam int RMC_BW_LSB  = 0;
    localparam int RMC_BW_W    = 4;
    localparam logic [2:0] RMC_LNA_PORT1 = 3'h0;
    localparam int RMC_SYNC_W = 24;
    localparam int RMC_CNT_W  = 5;
    localparam int RMC_ERR_W  = 9;
    localparam int RMC_ST_P1  = 0;
    localparam int RMC_ST_P2  = 1;
    localparam int RMC_ST_TRK = 2;
    localparam int RMC_ST_HLD = 3;
    localparam int RMC_ST_SYN = 4;
    typedef enum logic [1:0] {
        RMC_SLEEP = 2'b00,
        RMC_IDLE  = 2'b01,
        RMC_RX    = 2'b10,
        RMC_TX    = 2'b11
    } rmc_radio_t;
    typedef enum logic [1:0] {
        RMC_AFC_OFF   = 2'b00,
        RMC_AFC_TRACK = 2'b01,
        RMC_AFC_HOLD  = 2'b10
    } rmc_afc_t;
    typedef struct packed {
        logic [RMC_NREG-1:0][7:0]     regs;
        logic [7:0]                   rdata;
        logic                         pa;
        logic                         pa_oe;
        logic                         lna;
        logic                         lna_oe;
        logic                         port1;
        logic                         port2;
        logic [RMC_BW_W-1:0]          bb_bw;
        logic                         pkt;
        logic                         sport;
        rmc_afc_t                     afc;
        logic signed [RMC_ERR_W-1:0]  afc_off;
        logic                         sync_seen;
    } rmc_state_t;
    typedef struct packed {
        logic [RMC_SYNC_W-1:0] shreg;
        logic                  found;
    } rmc_sync_state_t;
endpackage

// File: verilog/rmc_sync_if.sv
interface rmc_sync_if;
    import rmc_pkg::*;
    logic [RMC_SYNC_W-1:0] pattern;
    logic [RMC_LEN_W-1:0]  len;
    logic [RMC_TOL_W-1:0]  tol;
    logic                  bit_in;
    logic                  bit_valid;
    logic                  found;
    modport cfg  (output pattern, len, tol, bit_in, bit_valid, input found);
    modport core (input pattern, len, tol, bit_in, bit_valid, output found);
endinterface

// File: verilog/rmc_sync_match.sv
module rmc_sync_match
    import rmc_pkg::*;
(
    input  wire logic sys_clk_i, // system clock
    input  wire logic sys_rst_i, // synchronous reset
    rmc_sync_if.core  sif        // pattern, bit stream, match
);
    rmc_sync_state_t        st;
    rmc_sync_state_t        next_st;
    logic [RMC_SYNC_W-1:0]  mask;
    logic [RMC_SYNC_W-1:0]  shifted;
    logic [RMC_CNT_W-1:0]   cur_errs;

    function automatic logic [RMC_CNT_W-1:0] rmc_count(input logic [RMC_SYNC_W-1:0] v);
        logic [RMC_CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < RMC_SYNC_W; i++) begin
            n = n + RMC_CNT_W'(v[i]);
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < RMC_SYNC_W; i++) begin
            mask[i] = (i < int'(sif.len));
        end
        // newest bit enters at bit 0, so byte one precedes byte zero on air
        shifted = {st.shreg[RMC_SYNC_W-2:0], sif.bit_in};
        next_st = st;
        next_st.found = 1'b0;
        if (sif.bit_valid) begin
            next_st.shreg = shifted;
            next_st.found = (sif.len != '0) &&
                (rmc_count((shifted ^ sif.pattern) & mask) <=
                 RMC_CNT_W'(sif.tol)); // see (RULE7) (RULE8)
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sif.found = st.found;
    assign cur_errs  = rmc_count((st.shreg ^ sif.pattern) & mask);

    ////////////////////////////////////////////////////////////////////////////
    property p_sync_cause;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        sif.found |-> $past(sif.bit_valid) && (st.shreg[0] == $past(sif.bit_in));
    endproperty
    a_sync_cause: assert property (p_sync_cause) else $error("match without bit"); // see (RULE7)

    property p_sync_exact;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (sif.found && sif.tol == '0 && $stable(sif.len)) |-> cur_errs == '0;
    endproperty
    a_sync_exact: assert property (p_sync_exact) else $error("inexact match"); // see (RULE7)

    property p_sync_tol;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (sif.found && $stable(sif.len)) |-> cur_errs <= RMC_CNT_W'($past(sif.tol));
    endproperty
    a_sync_tol: assert property (p_sync_tol) else $error("too many errors"); // see (RULE8)

    c_sync_hit: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) sif.found);
endmodule

// File: verilog/rmc_config_core.sv
// Operation
// (RULE1) host writes common settings, lock time 0x28 at 0x335, before GFSK/FSK use
// (RULE2) host writes rate set; rate is two bytes, upper byte first
// (RULE3) host programs preamble length only in packet mode; 0x04 gives 6 bytes
// (RULE4) host sets baseband bandwidth bits 3:0 to 0x6, or 0xD at 2 Mbps
// (RULE5) host writes mode 0x04 packet or 0x03 serial; serial also sets pin function
// (RULE6) sync bytes beyond sync length are filled with preamble pattern
// (RULE7) device matches sync word of programmed length, byte one before byte zero
// (RULE8) device accepts sync words with up to tolerance-field bit errors
// (RULE9) code 0x07 enables frequency correction, frozen at preamble detection
// (RULE10) correction pull-in limited by range register; 0x50 is plus/minus 80 kHz
// (RULE11) 802.15.4 packet mode works from reset defaults; serial needs shaping 0x01
// (RULE12) at most one RF port active; port 1 receive only, port 2 both
// (RULE13) receive uses port 2 when port select is 1, port 1 when 0
// (RULE14) with PA enable set, PA pin high in transmit, low elsewhere
// (RULE15) with LNA enable set, LNA pin high in receive, low elsewhere
// (RULE16) both enable pins float in sleep; board pulls them low
// (RULE17) diversity controller compares signal strength and switches during preamble; here the receive port follows only the port select field
// (RULE18) host issues restart before changing between GFSK/FSK and 802.15.4 modes
// (RULE19) host finishes configuration before any transmit or receive command
module rmc_config_core
    import rmc_pkg::*;
(
    input  wire logic                        sys_clk_i,          // 40 MHz clock
    input  wire logic                        sys_rst_i,          // sync reset
    input  wire logic                        reg_wr_i,           // register write
    input  wire logic                        reg_rd_i,           // register read
    input  wire logic [RMC_AW-1:0]           reg_addr_i,         // register location
    input  wire logic [7:0]                  reg_wdata_i,        // write data
    output logic      [7:0]                  reg_rdata_o,        // read data
    input  rmc_radio_t                       radio_state_i,      // controller state
    input  wire logic                        pa_auto_en_i,       // PA enable control
    input  wire logic                        lna_auto_en_i,      // LNA enable control
    input  wire logic                        rx_bit_i,           // demodulated bit
    input  wire logic                        rx_bit_valid_i,     // bit strobe
    input  wire logic                        preamble_det_i,     // preamble found
    input  wire logic signed [RMC_ERR_W-1:0] freq_err_i,         // offset, kHz
    output logic                             pa_enable_pin_o,    // PA enable level
    output logic                             pa_enable_pin_oe_o, // PA pin driven
    output logic                             lna_enable_pin_o,   // LNA enable level
    output logic                             lna_enable_pin_oe_o,// LNA pin driven
    output logic                             rf_port1_on_o,      // port 1 active
    output logic                             rf_port2_on_o,      // port 2 active
    output logic      [RMC_BW_W-1:0]         rx_bb_bw_o,         // baseband bandwidth
    output logic                             mode_packet_o,      // packet mode
    output logic                             mode_sport_o,       // serial mode
    output logic                             sync_found_o,       // sync pulse
    output logic                             afc_run_o,          // AFC tracking
    output logic signed [RMC_ERR_W-1:0]      afc_offset_o        // correction, kHz
);
    rmc_state_t                  st;
    rmc_state_t                  next_st;
    logic                        hit;
    logic [$clog2(RMC_NREG)-1:0] hit_idx;
    logic [RMC_LNA_W-1:0]        lna_sel;
    logic [7:0]                  rng;
    logic signed [RMC_ERR_W-1:0] lim;
    logic signed [RMC_ERR_W-1:0] clamped;
    logic                        rx_now;
    logic                        tx_now;
    logic                        awake;
    logic                        port1_next;
    logic [7:0]                  status;

    rmc_sync_if sif ();

    ////////////////////////////////////////////////////////////////////////////
    // sync pattern and bit stream towards the correlator
    assign sif.pattern = {st.regs[RMC_I_SYNC2], st.regs[RMC_I_SYNC1],
                          st.regs[RMC_I_SYNC0]};
    assign sif.len     = st.regs[RMC_I_SCFG][RMC_LEN_LSB +: RMC_LEN_W];
    assign sif.tol     = st.regs[RMC_I_SCFG][RMC_TOL_LSB +: RMC_TOL_W];
    assign sif.bit_in    = rx_bit_i;
    assign sif.bit_valid = rx_bit_valid_i && (radio_state_i == RMC_RX);

    rmc_sync_match u_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .sif       (sif.core)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode over the fixed location table
    always_comb begin
        hit     = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < RMC_NREG; i++) begin
            if (reg_addr_i == RMC_ADDR[i]) begin
                hit     = 1'b1;
                hit_idx = ($clog2(RMC_NREG))'(i);
            end
        end
    end

    assign lna_sel = st.regs[RMC_I_RXFE][RMC_LNA_LSB +: RMC_LNA_W];
    assign rng     = st.regs[RMC_I_AFCR];
    assign lim     = $signed({1'b0, rng});
    assign rx_now  = (radio_state_i == RMC_RX);
    assign tx_now  = (radio_state_i == RMC_TX);
    assign awake   = (radio_state_i != RMC_SLEEP);
    // any select value other than port 1 keeps the default port 2
    assign port1_next = rx_now && (lna_sel == RMC_LNA_PORT1);

    always_comb begin
        clamped = freq_err_i;
        if (freq_err_i > lim) begin
            clamped = lim; // see (RULE10)
        end else if (freq_err_i < -lim) begin
            clamped = -lim; // see (RULE10)
        end
    end

    always_comb begin
        status = '0;
        status[RMC_ST_P1]  = st.port1;
        status[RMC_ST_P2]  = st.port2;
        status[RMC_ST_TRK] = (st.afc == RMC_AFC_TRACK);
        status[RMC_ST_HLD] = (st.afc == RMC_AFC_HOLD);
        status[RMC_ST_SYN] = st.sync_seen;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        if (reg_wr_i && hit) begin
            next_st.regs[hit_idx] = reg_wdata_i;
        end
        if (reg_rd_i) begin
            if (hit) begin
                next_st.rdata = st.regs[hit_idx];
            end else if (reg_addr_i == RMC_STATUS_ADDR) begin
                next_st.rdata = status;
            end else begin
                next_st.rdata = RMC_ZERO_RST;
            end
        end
        // a write to status clears the sticky sync flag; a new match wins
        if (reg_wr_i && reg_addr_i == RMC_STATUS_ADDR) begin
            next_st.sync_seen = 1'b0;
        end
        if (sif.found) begin
            next_st.sync_seen = 1'b1;
        end
        // enables float in sleep, so the board pull-downs hold amplifiers off
        next_st.pa_oe  = awake; // see (RULE16)
        next_st.lna_oe = awake; // see (RULE16)
        next_st.pa     = awake && pa_auto_en_i && tx_now; // see (RULE14)
        next_st.lna    = awake && lna_auto_en_i && rx_now; // see (RULE15)
        // transmit is only possible on port 2
        next_st.port1 = port1_next; // see (RULE13)
        next_st.port2 = tx_now || (rx_now && !port1_next); // see (RULE12) (RULE13)
        next_st.bb_bw = st.regs[RMC_I_RXFE][RMC_BW_LSB +: RMC_BW_W];
        next_st.pkt   = (st.regs[RMC_I_MODE] == RMC_MODE_PKT);
        next_st.sport = (st.regs[RMC_I_MODE] == RMC_MODE_SPORT);
        case (st.afc)
            RMC_AFC_OFF: begin
                next_st.afc_off = '0;
                if (rx_now && st.regs[RMC_I_AFCC] == RMC_AFC_ON) begin
                    next_st.afc = RMC_AFC_TRACK; // see (RULE9)
                end
            end
            RMC_AFC_TRACK: begin
                next_st.afc_off = clamped; // see (RULE10)
                if (!rx_now || st.regs[RMC_I_AFCC] != RMC_AFC_ON) begin
                    next_st.afc     = RMC_AFC_OFF;
                    next_st.afc_off = '0;
                end else if (preamble_det_i) begin
                    next_st.afc = RMC_AFC_HOLD; // see (RULE9)
                end
            end
            RMC_AFC_HOLD: begin
                // frozen value held for the rest of the reception
                if (!rx_now) begin
                    next_st.afc     = RMC_AFC_OFF;
                    next_st.afc_off = '0;
                end
            end
            default: begin
                next_st.afc     = RMC_AFC_OFF;
                next_st.afc_off = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
            // defaults alone give 802.15.4 packet operation on port 2
            st.regs[RMC_I_RXFE] <= RMC_RXFE_RST; // see (RULE11)
            st.regs[RMC_I_PCHK] <= RMC_PCHK_RST; // see (RULE11)
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign reg_rdata_o         = st.rdata;
    assign pa_enable_pin_o     = st.pa;
    assign pa_enable_pin_oe_o  = st.pa_oe;
    assign lna_enable_pin_o    = st.lna;
    assign lna_enable_pin_oe_o = st.lna_oe;
    assign rf_port1_on_o       = st.port1;
    assign rf_port2_on_o       = st.port2;
    assign rx_bb_bw_o          = st.bb_bw;
    assign mode_packet_o       = st.pkt;
    assign mode_sport_o        = st.sport;
    assign sync_found_o        = sif.found;
    assign afc_run_o           = (st.afc == RMC_AFC_TRACK);
    assign afc_offset_o        = st.afc_off;

    ////////////////////////////////////////////////////////////////////////////
    property p_port_excl;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !(rf_port1_on_o && rf_port2_on_o) && !(rf_port1_on_o && $past(tx_now));
    endproperty
    a_port_excl: assert property (p_port_excl) else $error("two ports active"); // see (RULE12)

    property p_rx_route;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (rx_now && !(reg_wr_i && hit)) |=>
            (rf_port1_on_o == ($past(lna_sel) == RMC_LNA_PORT1)) &&
            (rf_port2_on_o == ($past(lna_sel) != RMC_LNA_PORT1));
    endproperty
    a_rx_route: assert property (p_rx_route) else $error("wrong rx port"); // see (RULE13)

    property p_default_port;
        @(posedge sys_clk_i)
        $past(sys_rst_i) && !sys_rst_i |-> lna_sel != RMC_LNA_PORT1;
    endproperty
    a_default_port: assert property (p_default_port) else $error("bad default"); // see (RULE11)

    property p_pa_tx;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (pa_auto_en_i && tx_now) |=> pa_enable_pin_o && pa_enable_pin_oe_o;
    endproperty
    a_pa_tx: assert property (p_pa_tx) else $error("PA not on in tx"); // see (RULE14)

    property p_pa_off;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (awake && !tx_now) |=> !pa_enable_pin_o && pa_enable_pin_oe_o;
    endproperty
    a_pa_off: assert property (p_pa_off) else $error("PA on outside tx"); // see (RULE14)

    property p_lna_rx;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        awake |=> lna_enable_pin_o == ($past(lna_auto_en_i) && $past(rx_now));
    endproperty
    a_lna_rx: assert property (p_lna_rx) else $error("LNA level wrong"); // see (RULE15)

    property p_sleep_float;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (radio_state_i == RMC_SLEEP) ##1 (radio_state_i == RMC_SLEEP) |->
            !pa_enable_pin_oe_o && !lna_enable_pin_oe_o;
    endproperty
    a_sleep_float: assert property (p_sleep_float) else $error("pin driven in sleep"); // see (RULE16)

    property p_afc_freeze;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (afc_run_o && rx_now && preamble_det_i && st.regs[RMC_I_AFCC] == RMC_AFC_ON)
            ##1 rx_now [*3] |=> $stable(afc_offset_o) && !afc_run_o;
    endproperty
    a_afc_freeze: assert property (p_afc_freeze) else $error("AFC not frozen"); // see (RULE9)

    property p_afc_range;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        afc_run_o |-> (afc_offset_o <= $signed({1'b0, $past(rng)})) &&
                      (afc_offset_o >= -$signed({1'b0, $past(rng)}));
    endproperty
    a_afc_range: assert property (p_afc_range) else $error("AFC beyond range"); // see (RULE10)

    c_pa_tx:    cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
                                pa_enable_pin_o);
    c_port1_rx: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
                                rf_port1_on_o);
    c_afc_hold: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
                                st.afc == RMC_AFC_HOLD);
endmodule

// File: dv/rmc_amp_model.sv
module rmc_amp_model (
    input  wire logic pa_lvl_i,  // pa enable level from block
    input  wire logic pa_oe_i,   // pa pin driven
    input  wire logic lna_lvl_i, // lna enable level from block
    input  wire logic lna_oe_i,  // lna pin driven
    output logic      pa_on_o,   // external pa powered
    output logic      lna_on_o   // external lna powered
);
    timeunit 1ns;
    timeprecision 1ps;
    // board pull-downs keep both amplifiers off while the pins float
    assign pa_on_o  = pa_oe_i ? pa_lvl_i : 1'b0;
    assign lna_on_o = lna_oe_i ? lna_lvl_i : 1'b0;
endmodule

// File: dv/tb_top.sv
module tb_top
    import rmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        sys_clk_i, sys_rst_i, wr, rd, pa_en, lna_en, bit_v, bit_d, pdet;
    logic [RMC_AW-1:0]           addr;
    logic [7:0]                  wdata, rdata;
    rmc_radio_t                  state;
    logic signed [RMC_ERR_W-1:0] ferr, afc_off;
    logic                        pa, pa_oe, lna, lna_oe, p1, p2, pkt, sport, found, run;
    logic                        pa_on, lna_on;
    logic [RMC_BW_W-1:0]         bw;
    int                          miscompares, check_count;
    rmc_config_core uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .radio_state_i(state), .pa_auto_en_i(pa_en), .lna_auto_en_i(lna_en),
        .rx_bit_i(bit_d), .rx_bit_valid_i(bit_v), .preamble_det_i(pdet), .freq_err_i(ferr),
        .pa_enable_pin_o(pa), .pa_enable_pin_oe_o(pa_oe), .lna_enable_pin_o(lna),
        .lna_enable_pin_oe_o(lna_oe), .rf_port1_on_o(p1), .rf_port2_on_o(p2),
        .rx_bb_bw_o(bw), .mode_packet_o(pkt), .mode_sport_o(sport), .sync_found_o(found),
        .afc_run_o(run), .afc_offset_o(afc_off));
    rmc_amp_model amp (.pa_lvl_i(pa), .pa_oe_i(pa_oe), .lna_lvl_i(lna), .lna_oe_i(lna_oe),
        .pa_on_o(pa_on), .lna_on_o(lna_on));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string name, logic [8:0] exp, logic [8:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wreg(logic [RMC_AW-1:0] a, logic [7:0] d);
        @(negedge sys_clk_i) begin addr = a; wdata = d; wr = 1'b1; end
        @(negedge sys_clk_i) wr = 1'b0;
    endtask
    task automatic rreg(string name, logic [RMC_AW-1:0] a, logic [7:0] exp);
        @(negedge sys_clk_i) begin addr = a; rd = 1'b1; end
        @(negedge sys_clk_i) rd = 1'b0;
        chk(name, {1'b0, exp}, {1'b0, rdata});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rreg("frontend rst", 10'h39b, 8'h10);
        rreg("pchk rst", 10'h3f3, 8'h05);
        rreg("unmapped", 10'h000, 8'h00);
        wreg(10'h335, 8'h28);
        wreg(10'h30e, 8'h09);
        wreg(10'h30f, 8'hc4);
        wreg(10'h102, 8'h04);
        rreg("lock time", 10'h335, 8'h28);
        rreg("rate upper", 10'h30e, 8'h09);
        rreg("rate lower", 10'h30f, 8'hc4);
        rreg("preamble", 10'h102, 8'h04);
    endtask
    task automatic t_modes();
        wreg(10'h39b, 8'h1d);
        repeat (2) @(negedge sys_clk_i);
        chk("bw 2m", 9'h00d, {5'h00, bw});
        wreg(10'h13e, 8'h04);
        repeat (2) @(negedge sys_clk_i);
        chk("packet", 9'h001, {7'h00, sport, pkt});
        // host commands stay outside: no mode family change without restart
        wreg(10'h13e, 8'h03);
        wreg(10'h32c, 8'h01);
        wreg(10'h306, 8'h01);
        repeat (2) @(negedge sys_clk_i);
        chk("sport", 9'h002, {7'h00, sport, pkt});
    endtask
    // every state under both port selections; model shows the floating pins
    task automatic t_ports();
        logic [1:0] exp_p;
        for (int sel = 1; sel >= 0; sel--) begin
            // port changes only between receptions, never inside payload
            wreg(10'h39b, {1'b0, sel[2:0], 4'h6});
            for (int s = 0; s < 4; s++) begin
                @(negedge sys_clk_i) state = rmc_radio_t'(s);
                repeat (2) @(negedge sys_clk_i);
                exp_p = (state == RMC_TX) ? 2'b10 :
                        (state == RMC_RX) ? ((sel == 0) ? 2'b01 : 2'b10) : 2'b00;
                chk("ports", {7'h00, exp_p}, {7'h00, p2, p1});
                chk("pa pin", {7'h00, state == RMC_TX, state == RMC_TX}, {7'h00, pa, pa_on});
                chk("lna pin", {7'h00, state == RMC_RX, state == RMC_RX}, {7'h00, lna, lna_on});
                chk("pin drive", {7'h00, {2{state != RMC_SLEEP}}}, {7'h00, pa_oe, lna_oe});
            end
        end
        chk("bw", 9'h006, {5'h00, bw});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_sync(logic [15:0] word, logic [1:0] tol, int exp);
        int n;
        n = 0;
        wreg(10'h10f, {1'b0, tol, 5'h10});
        @(negedge sys_clk_i) state = RMC_RX;
        for (int i = 0; i < 19; i++) begin
            @(negedge sys_clk_i) begin bit_v = (i < 16); bit_d = (i < 16) ? word[15-i] : 1'b0; end
            if (found === 1'b1) n++;
        end
        chk("sync hits", exp[8:0], n[8:0]);
    endtask
    task automatic t_afc();
        // whole set-up written before the next receive entry
        wreg(10'h3f7, 8'h07);
        wreg(10'h3f9, 8'h50);
        @(negedge sys_clk_i) begin state = RMC_IDLE; ferr = 9'sd100; end
        @(negedge sys_clk_i) state = RMC_RX;
        repeat (3) @(negedge sys_clk_i);
        chk("afc run", 9'h001, {8'h00, run});
        chk("afc clamp hi", 9'sd80, afc_off);
        @(negedge sys_clk_i) ferr = -9'sd100;
        repeat (2) @(negedge sys_clk_i);
        chk("afc clamp lo", -9'sd80, afc_off);
        @(negedge sys_clk_i) pdet = 1'b1;
        @(negedge sys_clk_i) ferr = 9'sd10;
        repeat (2) @(negedge sys_clk_i);
        chk("afc hold", {8'h00, 1'b0}, {8'h00, run});
        chk("afc frozen", -9'sd80, afc_off);
        @(negedge sys_clk_i) begin state = RMC_IDLE; pdet = 1'b0; end
        repeat (2) @(negedge sys_clk_i);
        chk("afc off", 9'h000, afc_off);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // hang guard, well above the whole sequence
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        miscompares++;
        print_verdict();
    end
    initial begin
        {wr, rd, bit_v, bit_d, pdet} = '0;
        {pa_en, lna_en} = 2'b11;
        addr = '0;
        wdata = '0;
        ferr = '0;
        state = RMC_SLEEP;
        sys_rst_i = 1'b1;
        miscompares = 0;
        check_count = 0;
        repeat (16) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        t_regs();
        t_modes();
        t_ports();
        @(negedge sys_clk_i) pa_en = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk("pa ctl off", 9'h000, {8'h00, pa});
        @(negedge sys_clk_i) pa_en = 1'b1;
        wreg(10'h10c, 8'h31);
        wreg(10'h10d, 8'h7f);
        wreg(10'h10e, 8'haa);
        t_sync(16'h7f31, 2'd0, 1);
        t_sync(16'h7f30, 2'd0, 0);
        t_sync(16'h7f30, 2'd1, 1);
        rreg("status seen", 10'h3fa, 8'h11);
        wreg(10'h3fa, 8'h00);
        rreg("status clr", 10'h3fa, 8'h01);
        t_afc();
        print_verdict();
    end
endmodule
